// ---- inc/fpc_params.svh ----
// constants for the flash program and erase controller
// Behaviour
// RQ1 - wipe refused by locks; debug wipe by wipe lock
// RQ2 - enable and ready registers open to non-secure
// RQ3 - non-secure enable governs non-secure writes only; code also applies it to secure writes to non-secure pages
// RQ4 - non-secure write to secure page stopped
// RQ5 - no write or erase below power threshold
// RQ6 - warning at request refuses with bus error; code acks register-started wipes and lock write with no error
// RQ7 - running write finishes; later writes refused
// RQ8 - warning aborts erase with bus error; code gives the error for page erase only, not whole or partial wipe
// RQ9 - cache hit answers with no wait state
// RQ10 - miss fetches from flash, waits for it
// RQ11 - disabled cache holds nothing valid
// RQ12 - profiling counts every hit and miss
// RQ13 - enable settings stay one-hot
// RQ14 - writing 1 starts whole wipe; 0 nothing
// RQ15 - software sets erase enable before whole wipe
// RQ16 - partial wipe duration in ms, reset ten
// RQ17 - software sums partial steps to full erase
// RQ18 - cache on bit 0; clearing invalidates all
// RQ19 - software writes a word at most twice
// RQ20 - word write within 43 us, ready low
// RQ21 - page erase within 87 ms
// RQ22 - whole wipe within 173 ms
// RQ23 - software never enables write and erase together
// RQ24 - programming only clears bits
// RQ25 - only aligned full-word flash writes
// RQ26 - all-ones to first page word erases page
// RQ27 - ready low while busy, high when free
// RQ28 - writing zero clears a profiling counter
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

`define FPC_OFF_READY       12'h400
`define FPC_OFF_READY_NEXT  12'h408
`define FPC_OFF_CFG_S       12'h504
`define FPC_OFF_WIPE_ALL    12'h50c
`define FPC_OFF_PART_DUR    12'h51c
`define FPC_OFF_CACHE_SETUP 12'h540
`define FPC_OFF_HIT         12'h548
`define FPC_OFF_MISS        12'h54c
`define FPC_OFF_CFG_NS      12'h584
`define FPC_OFF_NS_LOCK     12'h588
`define FPC_OFF_PART_GO     12'h5a0

`define FPC_CFG_WEN         0
`define FPC_CFG_EEN         1
`define FPC_CACHE_ON        0
`define FPC_CACHE_PROF      8
`define FPC_PART_DUR_RST    7'h0a
`define FPC_LOCK_WORD_ADDR  20'h00000

`define FPC_CLK_MHZ         10
`define FPC_CYC_PER_MS      (`FPC_CLK_MHZ * 1000)
`define FPC_WRITE_US        43
`define FPC_WRITE_CYCLES    (`FPC_WRITE_US * `FPC_CLK_MHZ)
`define FPC_PAGE_WIPE_MS    87
`define FPC_WHOLE_WIPE_MS   173

`endif

// ---- inc/fpc_pkg.sv ----
// types for the flash program and erase controller
package fpc_pkg;
  typedef enum logic [1:0] {OP_WRITE, OP_PAGE, OP_WHOLE, OP_PART} fpc_op_kind_t;
  typedef enum logic {C_IDLE, C_MISS} fpc_cache_state_t;
endpackage : fpc_pkg

// ---- hw/fpc_flash_controller.sv ----
// flash program/erase controller with instruction cache
`timescale 1ns/1ns
`include "fpc_params.svh"

module fpc_flash_controller #(
  parameter int unsigned PAGE_WIPE_CYCLES  = `FPC_PAGE_WIPE_MS * `FPC_CYC_PER_MS,
  parameter int unsigned WHOLE_WIPE_CYCLES = `FPC_WHOLE_WIPE_MS * `FPC_CYC_PER_MS,
  parameter int unsigned MS_CYCLES         = `FPC_CYC_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [20:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wbNonSecure,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        pageIsSecure,
  input  wire logic        secureDebugLockBit,
  input  wire logic        debugLockBit,
  input  wire logic        wipeLockBit,
  input  wire logic        dbgWipeReq,
  input  wire logic        pofCompOn,
  input  wire logic        pofWarn,
  output logic             flWrite,
  output logic             flPageErase,
  output logic             flWholeWipe,
  output logic      [19:0] flAddr,
  output logic      [31:0] flWrData,
  output logic             flRdReq,
  output logic      [19:0] flRdAddr,
  input  wire logic [31:0] flRdData,
  input  wire logic        flRdValid,
  input  wire logic        ifReq,
  input  wire logic [19:0] ifAddr,
  output logic             ifAck,
  output logic      [31:0] ifData
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0]  cfgS_r;
  logic [1:0]  cfgNs_r;
  logic [6:0]  partDur_r;
  logic        cacheOn_r;
  logic        cacheProf_r;
  logic [31:0] hit_r;
  logic [31:0] miss_r;
  logic        run_r;
  logic        hold_r;
  logic [23:0] cnt_r;
  fpc_pkg::fpc_op_kind_t kind_r;
  logic        ack_r;
  logic        err_r;
  logic [31:0] rdat_r;
  fpc_pkg::fpc_cache_state_t cst_r;
  logic [511:0] valid_r;
  logic [8:0]  tag_r [512];
  logic [31:0] line_r [512];
  logic        ifAck_r;
  logic [31:0] ifData_r;
  logic        flRdReq_r;
  logic [19:0] flRdAddr_r;
  logic [19:0] flAddr_r;
  logic [31:0] flWrData_r;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [1:0] fpc_one_hot(input logic [31:0] d);
    fpc_one_hot = (d[`FPC_CFG_WEN] & d[`FPC_CFG_EEN]) ? 2'h0 : d[1:0];
  endfunction : fpc_one_hot

  function automatic logic fpc_secure_only(input logic [11:0] off);
    fpc_secure_only = !(off == `FPC_OFF_READY || off == `FPC_OFF_READY_NEXT ||
                        off == `FPC_OFF_CFG_NS || off == `FPC_OFF_NS_LOCK);
  endfunction : fpc_secure_only

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  logic        req;
  logic        pofBlock;
  logic [11:0] off;
  logic [1:0]  cfgSel;
  logic        fullWord;
  logic        mapped;
  logic        regWr;
  logic        start;
  logic        startHold;
  fpc_pkg::fpc_op_kind_t startKind;
  logic [23:0] startLen;
  logic [19:0] startAddr;
  logic [31:0] startData;
  logic        respAck;
  logic        respErr;
  logic [31:0] rdMux;

  assign req      = wb_cyc_i & wb_stb_i & !ack_r & !err_r & !hold_r;
  assign pofBlock = pofCompOn & pofWarn;
  assign off      = wb_adr_i[11:0];
  assign cfgSel   = (wbNonSecure | !pageIsSecure) ? cfgNs_r : cfgS_r; // [RQ3]
  assign fullWord = (wb_sel_i == 4'hf) & (wb_adr_i[1:0] == 2'h0);
  assign regWr    = req & wb_we_i & !wb_adr_i[20] & fullWord & !respErr;

  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h0;
    unique case (off)
      `FPC_OFF_READY:       rdMux = {31'h0, !run_r}; // [RQ2] [RQ27]
      `FPC_OFF_READY_NEXT:  rdMux = {31'h0, !run_r}; // [RQ2] [RQ27]
      `FPC_OFF_CFG_S:       rdMux = {30'h0, cfgS_r};
      `FPC_OFF_WIPE_ALL:    rdMux = 32'h0;
      `FPC_OFF_PART_DUR:    rdMux = {25'h0, partDur_r};
      `FPC_OFF_CACHE_SETUP: rdMux = {23'h0, cacheProf_r, 7'h0, cacheOn_r};
      `FPC_OFF_HIT:         rdMux = hit_r;
      `FPC_OFF_MISS:        rdMux = miss_r;
      `FPC_OFF_CFG_NS:      rdMux = {30'h0, cfgNs_r}; // [RQ2]
      `FPC_OFF_NS_LOCK:     rdMux = 32'h0;
      `FPC_OFF_PART_GO:     rdMux = 32'h0;
      default:              mapped = 1'b0;
    endcase
  end

  always_comb begin
    start     = 1'b0;
    startHold = 1'b0;
    startKind = fpc_pkg::OP_WRITE;
    startLen  = 24'(`FPC_WRITE_CYCLES);
    startAddr = wb_adr_i[19:0];
    startData = wb_dat_i;
    respAck   = 1'b0;
    respErr   = 1'b0;
    if (req && wb_adr_i[20]) begin
      if (!wb_we_i) begin
        respErr = 1'b1;
      end else if (wbNonSecure && pageIsSecure) begin
        respErr = 1'b1; // [RQ4]
      end else if (!fullWord) begin
        respErr = 1'b1; // [RQ25]
      end else if (!run_r && !flRdReq_r) begin
        if (cfgSel[`FPC_CFG_EEN] && wb_dat_i == 32'hffffffff &&
            wb_adr_i[11:2] == 10'h0) begin
          if (pofBlock) begin
            respErr = 1'b1; // [RQ5] [RQ6]
          end else begin
            start     = 1'b1; // [RQ26]
            startHold = 1'b1;
            startKind = fpc_pkg::OP_PAGE;
            startLen  = 24'(PAGE_WIPE_CYCLES); // [RQ21]
          end
        end else if (cfgSel[`FPC_CFG_WEN]) begin
          if (pofBlock) begin
            respErr = 1'b1; // [RQ6] [RQ7]
          end else begin
            start     = 1'b1; // [RQ20]
            startHold = 1'b1;
          end
        end else begin
          respAck = 1'b1;
        end
      end
    end else if (req) begin
      if (!mapped || (wbNonSecure && fpc_secure_only(off))) begin
        respErr = 1'b1;
      end else begin
        respAck = 1'b1;
        if (wb_we_i && fullWord && !run_r && !flRdReq_r && !pofBlock) begin
          if (off == `FPC_OFF_WIPE_ALL && wb_dat_i[0] && cfgS_r[`FPC_CFG_EEN] &&
              !secureDebugLockBit && !debugLockBit && !wipeLockBit) begin
            start     = 1'b1; // [RQ1] [RQ14] [RQ15]
            startKind = fpc_pkg::OP_WHOLE;
            startLen  = 24'(WHOLE_WIPE_CYCLES); // [RQ22]
          end else if (off == `FPC_OFF_NS_LOCK && cfgNs_r[`FPC_CFG_WEN]) begin
            start     = 1'b1;
            startAddr = `FPC_LOCK_WORD_ADDR;
            startData = 32'h0;
          end else if (off == `FPC_OFF_PART_GO && cfgS_r[`FPC_CFG_EEN]) begin
            start     = 1'b1;
            startKind = fpc_pkg::OP_PART;
            startAddr = wb_dat_i[19:0];
            startLen  = 24'(partDur_r * MS_CYCLES); // [RQ16]
          end
        end
      end
    end
    if (!req && dbgWipeReq && !wipeLockBit && !run_r && !flRdReq_r && !pofBlock) begin
      start     = 1'b1; // [RQ1]
      startKind = fpc_pkg::OP_WHOLE;
      startLen  = 24'(WHOLE_WIPE_CYCLES);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgS_r      <= 2'h0;
      cfgNs_r     <= 2'h0;
      partDur_r   <= `FPC_PART_DUR_RST; // [RQ16]
      cacheOn_r   <= 1'b0;
      cacheProf_r <= 1'b0;
    end else if (regWr) begin
      if (off == `FPC_OFF_CFG_S) cfgS_r <= fpc_one_hot(wb_dat_i); // [RQ13]
      if (off == `FPC_OFF_CFG_NS) cfgNs_r <= fpc_one_hot(wb_dat_i); // [RQ13]
      if (off == `FPC_OFF_PART_DUR) partDur_r <= wb_dat_i[6:0];
      if (off == `FPC_OFF_CACHE_SETUP) begin
        cacheOn_r   <= wb_dat_i[`FPC_CACHE_ON]; // [RQ18]
        cacheProf_r <= wb_dat_i[`FPC_CACHE_PROF];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation sequencer
  logic opDone;
  logic opAbort;
  assign opAbort = run_r & (kind_r != fpc_pkg::OP_WRITE) & pofBlock; // [RQ8] [RQ5]
  assign opDone  = run_r & (cnt_r == 24'h0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_r      <= 1'b0;
      hold_r     <= 1'b0;
      cnt_r      <= 24'h0;
      kind_r     <= fpc_pkg::OP_WRITE;
      flAddr_r   <= 20'h0;
      flWrData_r <= 32'h0;
    end else if (start) begin
      run_r      <= 1'b1; // [RQ27]
      hold_r     <= startHold;
      cnt_r      <= startLen - 24'h1;
      kind_r     <= startKind;
      flAddr_r   <= startAddr;
      flWrData_r <= startData; // [RQ24]
    end else if (opAbort || opDone) begin
      run_r  <= 1'b0; // [RQ7]
      hold_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r - 24'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flWrite     <= 1'b0;
      flPageErase <= 1'b0;
      flWholeWipe <= 1'b0;
    end else begin
      flWrite     <= start ? (startKind == fpc_pkg::OP_WRITE) : (flWrite & !opDone);
      flPageErase <= start ? (startKind == fpc_pkg::OP_PAGE || startKind == fpc_pkg::OP_PART)
                           : (flPageErase & !opDone & !opAbort); // [RQ8]
      flWholeWipe <= start ? (startKind == fpc_pkg::OP_WHOLE)
                           : (flWholeWipe & !opDone & !opAbort);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r  <= 1'b0;
      err_r  <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r  <= (respAck && !start) || (start && !startHold) ||
                (hold_r && opDone && !opAbort);
      err_r  <= respErr || (hold_r && opAbort); // [RQ6] [RQ8]
      rdat_r <= (req && !wb_we_i && !wb_adr_i[20]) ? rdMux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction cache
  logic [8:0] idx;
  logic       hit;
  logic       fetchReq;
  assign idx      = ifAddr[10:2];
  assign fetchReq = ifReq & !ifAck_r & (cst_r == fpc_pkg::C_IDLE);
  assign hit      = fetchReq & cacheOn_r & valid_r[idx] & (tag_r[idx] == ifAddr[19:11]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cst_r      <= fpc_pkg::C_IDLE;
      ifAck_r    <= 1'b0;
      ifData_r   <= 32'h0;
      flRdReq_r  <= 1'b0;
      flRdAddr_r <= 20'h0;
    end else begin
      ifAck_r <= 1'b0;
      unique case (cst_r)
        fpc_pkg::C_IDLE: begin
          if (hit) begin
            ifAck_r  <= 1'b1; // [RQ9]
            ifData_r <= line_r[idx];
          end else if (fetchReq && !run_r && !start) begin
            flRdReq_r  <= 1'b1; // [RQ10]
            flRdAddr_r <= {ifAddr[19:2], 2'h0};
            cst_r      <= fpc_pkg::C_MISS;
          end
        end
        fpc_pkg::C_MISS: begin
          if (flRdValid) begin
            flRdReq_r <= 1'b0;
            ifAck_r   <= 1'b1; // [RQ10]
            ifData_r  <= flRdData;
            cst_r     <= fpc_pkg::C_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (cst_r == fpc_pkg::C_MISS && flRdValid) begin
      line_r[flRdAddr_r[10:2]] <= flRdData;
      tag_r[flRdAddr_r[10:2]]  <= flRdAddr_r[19:11];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      valid_r <= 512'h0;
    end else if (!cacheOn_r) begin
      valid_r <= 512'h0; // [RQ11] [RQ18]
    end else if (cst_r == fpc_pkg::C_MISS && flRdValid) begin
      valid_r[flRdAddr_r[10:2]] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // profiling counters
  logic missEv;
  assign missEv = fetchReq & !hit & !run_r & !start;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_r <= 32'h0;
    end else if (regWr && off == `FPC_OFF_HIT && wb_dat_i == 32'h0) begin
      hit_r <= {31'h0, hit & cacheProf_r}; // [RQ28]
    end else if (hit && cacheProf_r) begin
      hit_r <= hit_r + 32'h1; // [RQ12]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      miss_r <= 32'h0;
    end else if (regWr && off == `FPC_OFF_MISS && wb_dat_i == 32'h0) begin
      miss_r <= {31'h0, missEv & cacheProf_r}; // [RQ28]
    end else if (missEv && cacheProf_r) begin
      miss_r <= miss_r + 32'h1; // [RQ12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = rdat_r;
  assign flAddr   = flAddr_r;
  assign flWrData = flWrData_r;
  assign flRdReq  = flRdReq_r;
  assign flRdAddr = flRdAddr_r;
  assign ifAck    = ifAck_r;
  assign ifData   = ifData_r;

endmodule : fpc_flash_controller

// ---- bench/fpc_checker_assertions.sv ----
// port checks for the flash controller
`timescale 1ns/1ns
module fpc_checker #(
  parameter int unsigned WHOLE_WIPE_CYCLES = 300
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [3:0] wb_sel_i,
  input wire logic       wbNonSecure,
  input wire logic       pageIsSecure,
  input wire logic       wb_ack_o,
  input wire logic       wb_err_o,
  input wire logic       wipeLockBit,
  input wire logic       pofCompOn,
  input wire logic       pofWarn,
  input wire logic       flWrite,
  input wire logic       flPageErase,
  input wire logic       flWholeWipe,
  input wire logic       flRdValid,
  input wire logic       ifAck
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  int unsigned wipeCnt;
  ////////////////////////////////////////////////////////////////////////////////
  // wipe length counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) wipeCnt <= 0;
    else wipeCnt <= flWholeWipe ? wipeCnt + 1 : 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_wipeLock; $rose(flWholeWipe) |-> !$past(wipeLockBit); endproperty
  a_wipeLock: assert property (p_wipeLock) else $error("wipe under lock");
  property p_nsSecure; $rose(flWrite) |-> !$past(wbNonSecure && pageIsSecure); endproperty
  a_nsSecure: assert property (p_nsSecure) else $error("ns write to secure page");
  property p_pofBlock;
    $rose(flWrite || flPageErase || flWholeWipe) |-> !$past(pofCompOn && pofWarn);
  endproperty
  a_pofBlock: assert property (p_pofBlock) else $error("op under warning");
  property p_eraseAbort; flPageErase && pofCompOn && pofWarn |-> ##[1:2] !flPageErase; endproperty
  a_eraseAbort: assert property (p_eraseAbort) else $error("erase not aborted");
  property p_writeTime; $rose(flWrite) |-> ##[1:430] !flWrite; endproperty
  a_writeTime: assert property (p_writeTime) else $error("write too long");
  property p_writeAck; $fell(flWrite) |-> wb_ack_o && !wb_err_o; endproperty
  a_writeAck: assert property (p_writeAck) else $error("write not acked");
  property p_wholeTime; wipeCnt <= WHOLE_WIPE_CYCLES; endproperty
  a_wholeTime: assert property (p_wholeTime) else $error("wipe too long");
  property p_pageTime; $rose(flPageErase) |-> ##[1:1000] !flPageErase; endproperty
  a_pageTime: assert property (p_pageTime) else $error("erase too long");
  property p_alignOnly; $rose(flWrite) |-> $past(wb_sel_i) == 4'hf; endproperty
  a_alignOnly: assert property (p_alignOnly) else $error("partial write");
  property p_missAck; flRdValid |=> ifAck; endproperty
  a_missAck: assert property (p_missAck) else $error("miss not answered");
  c_write: cover property ($rose(flWrite));
  c_wipe: cover property ($rose(flWholeWipe));
  c_miss: cover property (flRdValid);
  c_err: cover property (wb_err_o);
endmodule : fpc_checker
bind fpc_flash_controller fpc_checker #(.WHOLE_WIPE_CYCLES(WHOLE_WIPE_CYCLES)) i_fpc_checker (
  .clk, .rst_b, .wb_sel_i, .wbNonSecure, .pageIsSecure, .wb_ack_o, .wb_err_o, .wipeLockBit,
  .pofCompOn, .pofWarn, .flWrite, .flPageErase, .flWholeWipe, .flRdValid, .ifAck);

// ---- bench/fpc_flash_model.sv ----
// behavioural flash array behind the controller
`timescale 1ns/1ns
module fpc_flash_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        flWrite,
  input  wire logic        flPageErase,
  input  wire logic        flWholeWipe,
  input  wire logic [19:0] flAddr,
  input  wire logic [31:0] flWrData,
  input  wire logic        flRdReq,
  input  wire logic [19:0] flRdAddr,
  output logic      [31:0] flRdData,
  output logic             flRdValid
);
  logic [31:0] mem [16];
  logic        wrPrev;
  int          rdWait;
  initial begin
    foreach (mem[i]) mem[i] = 32'hffffffff;
    flRdData = 32'h0;
    flRdValid = 1'b0;
    wrPrev = 1'b0;
    rdWait = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    wrPrev <= flWrite;
    if (flWrite && !wrPrev) mem[flAddr[5:2]] <= mem[flAddr[5:2]] & flWrData;
    if (flPageErase || flWholeWipe) begin
      foreach (mem[i]) mem[i] <= 32'hffffffff;
    end
    flRdValid <= 1'b0;
    flRdData <= ~flRdData;
    if (flRdReq && !flRdValid) begin
      rdWait <= rdWait + 1;
      if (rdWait >= (slow ? 6 : 1)) begin
        flRdValid <= 1'b1;
        flRdData <= mem[flRdAddr[5:2]];
        rdWait <= 0;
      end
    end
  end
endmodule : fpc_flash_model

// ---- bench/test_flash_program_erase_controller.sv ----
// self-checking bench for the flash program and erase controller
`timescale 1ns/1ns
module test_flash_program_erase_controller;
  logic        clk, rst_b, cyc, stb, we, ns, pgSec, secLock, dbgLock, wipeLock, dbgWipe;
  logic        pofOn, pofWarn, ack, err, flWrite, flPageErase, flWholeWipe, e;
  logic        flRdReq, flRdValid, ifReq, ifAck, slow;
  logic [20:0] adr;
  logic [3:0]  sel;
  logic [31:0] datI, datO, flWrData, flRdData, ifData, q;
  logic [19:0] flAddr, flRdAddr, ifAddr;
  int          failures, checksDone;
  fpc_flash_controller #(.PAGE_WIPE_CYCLES(200), .WHOLE_WIPE_CYCLES(300), .MS_CYCLES(20))
    i_fpc_flash_controller (.clk, .rst_b, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wbNonSecure(ns), .wb_dat_o(datO),
    .wb_ack_o(ack), .wb_err_o(err), .pageIsSecure(pgSec), .secureDebugLockBit(secLock),
    .debugLockBit(dbgLock), .wipeLockBit(wipeLock), .dbgWipeReq(dbgWipe), .pofCompOn(pofOn),
    .pofWarn, .flWrite, .flPageErase, .flWholeWipe, .flAddr, .flWrData, .flRdReq,
    .flRdAddr, .flRdData, .flRdValid, .ifReq, .ifAddr, .ifAck, .ifData);
  fpc_flash_model i_fpc_flash_model (.clk, .slow, .flWrite, .flPageErase, .flWholeWipe,
    .flAddr, .flWrData, .flRdReq, .flRdAddr, .flRdData, .flRdValid);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic ok, input string msg);
    checksDone++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [20:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 5000);
    if (n >= 5000) chk(1'b0, "bus timeout");
    if (n >= 5000) end_of_test();
    q = datO;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [20:0] a, input logic [31:0] d, input logic xe);
    bus(1'b1, a, d, 4'hf);
    chk(e === xe, "write response");
  endtask : wr
  task automatic rd(input logic [20:0] a, input logic [31:0] x, input logic xe);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(e === xe && (xe || q === x), "read value");
  endtask : rd
  task automatic idle;
    int n;
    n = 0;
    while ((flWrite | flPageErase | flWholeWipe) !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk(n < 5000, "operation hung");
  endtask : idle
  task automatic fetch(input logic [19:0] a, input logic [31:0] x, input int xn);
    int n;
    ifReq <= 1'b1;
    ifAddr <= a;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ifAck !== 1'b1 && n < 100);
    ifReq <= 1'b0;
    chk(ifData === x && (xn > 0 ? n == xn : n > 3), "fetch");
    @(posedge clk);
  endtask : fetch
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    end_of_test();
  end
  initial begin
    {cyc, stb, we, ns, pgSec, secLock, dbgLock, wipeLock, dbgWipe} = '0;
    {pofOn, pofWarn, ifReq, slow, rst_b} = '0;
    adr = '0;
    sel = '0;
    datI = '0;
    ifAddr = '0;
    failures = 0;
    checksDone = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(21'h51c, 32'h0000000a, 1'b0);
    rd(21'h540, 32'h0, 1'b0);
    rd(21'h548, 32'h0, 1'b0);
    rd(21'h400, 32'h1, 1'b0);
    rd(21'h7fc, 32'h0, 1'b1);
    wr(21'h504, 32'h3, 1'b0);
    rd(21'h504, 32'h0, 1'b0);
    $display("test registers done");
    wr(21'h504, 32'h1, 1'b0);
    pgSec <= 1'b1;
    wr(21'h100004, 32'h0000ffff, 1'b0);
    wr(21'h100004, 32'hffff00ff, 1'b0);
    chk(i_fpc_flash_model.mem[1] === 32'h000000ff, "bits only cleared");
    bus(1'b1, 21'h100008, 32'h0, 4'h3);
    chk(e === 1'b1, "halfword write");
    wr(21'h10000a, 32'h0, 1'b1);
    ns <= 1'b1;
    wr(21'h100008, 32'h0, 1'b1);
    wr(21'h504, 32'h1, 1'b1);
    rd(21'h408, 32'h1, 1'b0);
    pgSec <= 1'b0;
    wr(21'h100008, 32'h0, 1'b0);
    chk(i_fpc_flash_model.mem[2] === 32'hffffffff, "ns write ignored");
    wr(21'h584, 32'h1, 1'b0);
    wr(21'h100008, 32'h0a0b0c0d, 1'b0);
    chk(i_fpc_flash_model.mem[2] === 32'h0a0b0c0d, "ns write");
    ns <= 1'b0;
    $display("test writes done");
    pofOn <= 1'b1;
    pofWarn <= 1'b1;
    wr(21'h10000c, 32'h0, 1'b1);
    chk(i_fpc_flash_model.mem[3] === 32'hffffffff, "write under warning");
    pofWarn <= 1'b0;
    fork
      wr(21'h10000c, 32'hf0f0f0f0, 1'b0);
      begin
        repeat (100) @(posedge clk);
        pofWarn <= 1'b1;
      end
    join
    chk(i_fpc_flash_model.mem[3] === 32'hf0f0f0f0, "write finished");
    wr(21'h100010, 32'h0, 1'b1);
    pofWarn <= 1'b0;
    pgSec <= 1'b1;
    wr(21'h504, 32'h2, 1'b0);
    wr(21'h100000, 32'hffffffff, 1'b0);
    chk(i_fpc_flash_model.mem[3] === 32'hffffffff, "page erased");
    fork
      wr(21'h100000, 32'hffffffff, 1'b1);
      begin
        repeat (50) @(posedge clk);
        pofWarn <= 1'b1;
      end
    join
    pofWarn <= 1'b0;
    $display("test power fail done");
    for (int k = 0; k < 3; k++) begin
      {secLock, dbgLock, wipeLock} <= 3'b100 >> k;
      wr(21'h50c, 32'h1, 1'b0);
      chk(flWholeWipe === 1'b0, "wipe refused");
      dbgWipe <= 1'b1;
      @(posedge clk);
      dbgWipe <= 1'b0;
      repeat (2) @(posedge clk);
      chk(flWholeWipe === (k < 2), "debug wipe");
      idle();
    end
    {secLock, dbgLock, wipeLock} <= 3'b000;
    wr(21'h50c, 32'h0, 1'b0);
    chk(flWholeWipe === 1'b0, "zero trigger");
    wr(21'h504, 32'h1, 1'b0);
    wr(21'h50c, 32'h1, 1'b0);
    chk(flWholeWipe === 1'b0, "wipe without enable");
    wr(21'h100008, 32'h0a0b0c0d, 1'b0);
    wr(21'h504, 32'h2, 1'b0);
    wr(21'h50c, 32'h1, 1'b0);
    chk(flWholeWipe === 1'b1, "wipe started");
    idle();
    chk(i_fpc_flash_model.mem[2] === 32'hffffffff, "wiped");
    rd(21'h400, 32'h1, 1'b0);
    wr(21'h51c, 32'h1, 1'b0);
    rd(21'h51c, 32'h1, 1'b0);
    wr(21'h5a0, 32'h0, 1'b0);
    chk(flPageErase === 1'b1, "partial erase");
    rd(21'h400, 32'h0, 1'b0);
    idle();
    $display("test wipe done");
    wr(21'h504, 32'h1, 1'b0);
    wr(21'h100008, 32'h0a0b0c0d, 1'b0);
    wr(21'h540, 32'h00000101, 1'b0);
    rd(21'h540, 32'h00000101, 1'b0);
    fetch(20'h00008, 32'h0a0b0c0d, 0);
    fetch(20'h00008, 32'h0a0b0c0d, 2);
    rd(21'h548, 32'h1, 1'b0);
    rd(21'h54c, 32'h1, 1'b0);
    wr(21'h548, 32'h0, 1'b0);
    rd(21'h548, 32'h0, 1'b0);
    wr(21'h540, 32'h00000100, 1'b0);
    wr(21'h540, 32'h00000101, 1'b0);
    slow <= 1'b1;
    fetch(20'h00008, 32'h0a0b0c0d, 0);
    rd(21'h54c, 32'h2, 1'b0);
    $display("test cache done");
    end_of_test();
  end
endmodule : test_flash_program_erase_controller
